// >>> hdl/rsr_readout.sv
// rate sample readout: sample byte registers, status and auto-increment
//
// Contract
// - each axis sample is presented as a 16-bit two's complement word.
// - bytes sit X, Y, Z at consecutive addresses, high byte first.
// - direct mode follows the sample rate; buffered mode shows the FIFO head.
// - direct mode high-byte read latches that axis low byte; host reads high first.
// - buffered mode X high read loads the other five bytes; host starts there.
// - buffered mode FIFO head advances only on a Z high-byte read.
// - after Z low, auto-increment goes to 0x00 or X high by wrap_select.
// - status clears on standby-to-active or ready-to-active.
// - status byte holds overrun flags in bits 7:4 and fresh flags in 3:0.
// - combined overrun sets when a new sample beats the previous retrieval.
// - combined overrun clears once all three high bytes were read.
// - sample registers are zero after power-on reset only.
// - address 0x00 mirrors ready status directly, FIFO status when buffered.
// - combined fresh sets on any new sample, clears after all high reads.
// - axis fresh sets on acquisition, clears on that axis high read.
`timescale 1ns/1ps
module rsr_readout
   import rsr_pkg::*;
#(
   parameter int SAMPLE_W = RSR_SAMPLE_W,
   parameter int BUF_DEPTH = RSR_BUF_DEPTH
) (
   // clock, reset and freeze
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // new samples from the acquisition path
   input wire logic smp_valid,
   input wire logic [SAMPLE_W-1:0] smp_x,
   input wire logic [SAMPLE_W-1:0] smp_y,
   input wire logic [SAMPLE_W-1:0] smp_z,
   output logic smp_ready,
   // head of the sample FIFO
   input wire logic [SAMPLE_W-1:0] head_x,
   input wire logic [SAMPLE_W-1:0] head_y,
   input wire logic [SAMPLE_W-1:0] head_z,
   input wire logic [7:0] fifo_status,
   output logic head_advance,
   // configuration fields held elsewhere
   input wire logic [1:0] fifo_mode,
   input wire logic [1:0] op_mode,
   input wire logic wrap_select,
   // register read port from the serial interface engine
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   output logic [7:0] reg_rd_data,
   output logic reg_rd_valid,
   output logic [7:0] reg_next_addr
);

   localparam int BUF_W = 3 * SAMPLE_W;

   // ----------------------------------------------------------------
   // address helpers
   // ----------------------------------------------------------------
   function automatic logic is_sample_addr(input logic [7:0] a);
      return (a >= RSR_ADDR_X_HIGH) && (a <= RSR_ADDR_Z_LOW);
   endfunction

   // high bytes sit at odd offsets, low bytes right after them
   function automatic logic is_high_addr(input logic [7:0] a);
      return is_sample_addr(a) && a[0];
   endfunction

   function automatic logic [1:0] axis_of(input logic [7:0] a);
      logic [7:0] rel;
      rel = a - RSR_ADDR_X_HIGH;
      return rel[2:1];
   endfunction

   function automatic logic [7:0] high_byte(input logic [SAMPLE_W-1:0] w);
      return w[SAMPLE_W-1 -: 8];
   endfunction

   function automatic logic [7:0] low_byte(input logic [SAMPLE_W-1:0] w);
      return w[7:0];
   endfunction

   // ----------------------------------------------------------------
   // sample buffer
   // ----------------------------------------------------------------
   logic buf_valid;
   logic buf_ready;
   logic [BUF_W-1:0] buf_data;
   logic direct_mode;

   assign direct_mode = (fifo_mode == RSR_FIFO_MODE_DIRECT);

   // drain stalls during a register read so a high-byte latch sees a stable
   // word; in buffered mode the buffer is never drained, so intake stops once it is full
   assign buf_ready = direct_mode && !reg_rd;

   rsr_skid_buf #(
      .WIDTH(BUF_W),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .in_valid(smp_valid),
      .in_data({smp_x, smp_y, smp_z}),
      .in_ready(smp_ready),
      .out_valid(buf_valid),
      .out_data(buf_data),
      .out_ready(buf_ready)
   );

   // ----------------------------------------------------------------
   // status flags
   // ----------------------------------------------------------------
   logic new_sample;
   logic [2:0] high_read;
   logic mode_clear;
   logic [1:0] op_mode_q, op_mode_d;
   logic [7:0] ready_state;

   assign new_sample = buf_valid && buf_ready;

   always_comb
   begin
      op_mode_d = op_mode;
      high_read = 3'h0;
      if (reg_rd && is_high_addr(reg_addr))
      begin
         high_read[axis_of(reg_addr)] = 1'b1;
      end
      mode_clear = (op_mode == RSR_OP_ACTIVE) && ((op_mode_q == RSR_OP_STANDBY)
                   || (op_mode_q == RSR_OP_READY));
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         op_mode_q <= RSR_OP_STANDBY;
      end
      else if (clk_en)
      begin
         op_mode_q <= op_mode_d;
      end
   end

   rsr_status_flags u_flags (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .new_sample(new_sample),
      .high_read(high_read),
      .mode_clear(mode_clear),
      .status(ready_state)
   );

   // ----------------------------------------------------------------
   // sample and snapshot registers
   // ----------------------------------------------------------------
   // live_q follows the sample rate; snap_q holds what a high-byte read latched for the later byte reads
   logic [SAMPLE_W-1:0] live_q [RSR_AXES];
   logic [SAMPLE_W-1:0] live_d [RSR_AXES];
   logic [SAMPLE_W-1:0] snap_q [RSR_AXES];
   logic [SAMPLE_W-1:0] snap_d [RSR_AXES];
   logic [SAMPLE_W-1:0] head_w [RSR_AXES];
   logic [SAMPLE_W-1:0] buf_w [RSR_AXES];
   logic [1:0] ax;

   assign head_w[RSR_AXIS_X] = head_x;
   assign head_w[RSR_AXIS_Y] = head_y;
   assign head_w[RSR_AXIS_Z] = head_z;
   assign buf_w[RSR_AXIS_X] = buf_data[3*SAMPLE_W-1 -: SAMPLE_W];
   assign buf_w[RSR_AXIS_Y] = buf_data[2*SAMPLE_W-1 -: SAMPLE_W];
   assign buf_w[RSR_AXIS_Z] = buf_data[SAMPLE_W-1:0];
   assign ax = axis_of(reg_addr);

   always_comb
   begin
      for (int i = 0; i < RSR_AXES; i++)
      begin
         live_d[i] = new_sample ? buf_w[i] : live_q[i];
         snap_d[i] = snap_q[i];
      end
      if (reg_rd && is_high_addr(reg_addr))
      begin
         if (direct_mode)
         begin
            snap_d[ax] = live_q[ax];
         end
         else if (ax == RSR_AXIS_X)
         begin
            for (int i = 0; i < RSR_AXES; i++)
            begin
               snap_d[i] = head_w[i];
            end
         end
      end
   end

   // power-on reset clears the bytes; a mode change leaves them alone
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < RSR_AXES; i++)
         begin
            live_q[i] <= RSR_RST_SAMPLE;
            snap_q[i] <= RSR_RST_SAMPLE;
         end
      end
      else if (clk_en)
      begin
         for (int i = 0; i < RSR_AXES; i++)
         begin
            live_q[i] <= live_d[i];
            snap_q[i] <= snap_d[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // read data, head advance and auto-increment
   // ----------------------------------------------------------------
   logic [7:0] rd_data_q, rd_data_d;
   logic rd_valid_q, rd_valid_d;
   logic [7:0] next_addr_q, next_addr_d;
   logic advance_q, advance_d;

   always_comb
   begin
      rd_data_d = rd_data_q;
      rd_valid_d = reg_rd;
      next_addr_d = next_addr_q;
      advance_d = 1'b0;
      if (reg_rd)
      begin
         next_addr_d = reg_addr + 8'h01;
         if (reg_addr == RSR_ADDR_Z_LOW)
         begin
            next_addr_d = wrap_select ? RSR_ADDR_X_HIGH : RSR_ADDR_STATUS_ALIAS;
         end
         if (reg_addr == RSR_ADDR_STATUS_ALIAS)
         begin
            rd_data_d = direct_mode ? ready_state : fifo_status;
         end
         else if (reg_addr == RSR_ADDR_READY_STATE)
         begin
            rd_data_d = ready_state;
         end
         else if (is_high_addr(reg_addr))
         begin
            if (direct_mode)
            begin
               rd_data_d = high_byte(live_q[ax]);
            end
            else if (ax == RSR_AXIS_X)
            begin
               rd_data_d = high_byte(head_x);
            end
            else
            begin
               rd_data_d = high_byte(snap_q[ax]);
            end
            // only a Z high read moves the FIFO head on
            advance_d = !direct_mode && (ax == RSR_AXIS_Z);
         end
         else if (is_sample_addr(reg_addr))
         begin
            // low byte is only meaningful after its high byte (in buffered mode the X high byte) was read
            rd_data_d = low_byte(snap_q[ax]);
         end
         else
         begin
            rd_data_d = RSR_RST_BYTE;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rd_data_q <= RSR_RST_BYTE;
         rd_valid_q <= 1'b0;
         next_addr_q <= RSR_ADDR_STATUS_ALIAS;
         advance_q <= 1'b0;
      end
      else if (clk_en)
      begin
         rd_data_q <= rd_data_d;
         rd_valid_q <= rd_valid_d;
         next_addr_q <= next_addr_d;
         advance_q <= advance_d;
      end
   end

   assign reg_rd_data = rd_data_q;
   assign reg_rd_valid = rd_valid_q;
   assign reg_next_addr = next_addr_q;
   assign head_advance = advance_q;

endmodule

// >>> inc/rsr_pkg.sv
// constants shared by the rate sample readout block
package rsr_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] RSR_ADDR_STATUS_ALIAS = 8'h00;
   localparam logic [7:0] RSR_ADDR_X_HIGH = 8'h01;
   localparam logic [7:0] RSR_ADDR_X_LOW = 8'h02;
   localparam logic [7:0] RSR_ADDR_Y_HIGH = 8'h03;
   localparam logic [7:0] RSR_ADDR_Y_LOW = 8'h04;
   localparam logic [7:0] RSR_ADDR_Z_HIGH = 8'h05;
   localparam logic [7:0] RSR_ADDR_Z_LOW = 8'h06;
   localparam logic [7:0] RSR_ADDR_READY_STATE = 8'h07;

   // ----------------------------------------------------------------
   // sample_ready_state field positions
   // ----------------------------------------------------------------
   localparam int RSR_BIT_ALL_OVERRUN = 7;
   localparam int RSR_BIT_Z_OVERRUN = 6;
   localparam int RSR_BIT_Y_OVERRUN = 5;
   localparam int RSR_BIT_X_OVERRUN = 4;
   localparam int RSR_BIT_ALL_FRESH = 3;
   localparam int RSR_BIT_Z_FRESH = 2;
   localparam int RSR_BIT_Y_FRESH = 1;
   localparam int RSR_BIT_X_FRESH = 0;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RSR_RST_BYTE = 8'h00;
   localparam logic [15:0] RSR_RST_SAMPLE = 16'h0000;
   localparam logic [2:0] RSR_RST_FLAGS = 3'h0;

   // ----------------------------------------------------------------
   // modes and sizes
   // ----------------------------------------------------------------
   localparam logic [1:0] RSR_FIFO_MODE_DIRECT = 2'h0;
   localparam logic [1:0] RSR_OP_STANDBY = 2'h0;
   localparam logic [1:0] RSR_OP_READY = 2'h1;
   localparam logic [1:0] RSR_OP_ACTIVE = 2'h2;
   localparam int RSR_SAMPLE_W = 16;
   localparam int RSR_AXES = 3;
   localparam int RSR_BUF_DEPTH = 2;

   typedef enum logic [1:0] {
      RSR_AXIS_X,
      RSR_AXIS_Y,
      RSR_AXIS_Z
   } rsr_axis_e;

endpackage

// >>> hdl/rsr_skid_buf.sv
// small valid/ready buffer between acquisition and readout
`timescale 1ns/1ps
module rsr_skid_buf #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic ready_q, ready_d;
   logic push, pop;

   assign push = in_valid && ready_q;
   assign pop = out_valid && out_ready;
   assign in_ready = ready_q;
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];

   always_comb
   begin
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (push)
      begin
         wr_d = (wr_q == PTR_LAST) ? '0 : wr_q + PW'(1);
      end
      if (pop)
      begin
         rd_d = (rd_q == PTR_LAST) ? '0 : rd_q + PW'(1);
      end
      if (push && !pop)
      begin
         cnt_d = cnt_q + CW'(1);
      end
      else if (pop && !push)
      begin
         cnt_d = cnt_q - CW'(1);
      end
      // registered ready keeps the fill side free of a path from the drain
      ready_d = (cnt_d != CNT_FULL);
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         ready_q <= 1'b0;
      end
      else if (clk_en)
      begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         ready_q <= ready_d;
      end
   end

   always_ff @(posedge clk)
   begin
      if (clk_en && push)
      begin
         mem_q[wr_q] <= in_data;
      end
   end

endmodule

// >>> hdl/rsr_status_flags.sv
// data-ready and overwrite flags of sample_ready_state
`timescale 1ns/1ps
module rsr_status_flags
   import rsr_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // events
   input wire logic new_sample,
   input wire logic [2:0] high_read,
   input wire logic mode_clear,
   // status byte
   output logic [7:0] status
);

   logic [2:0] fresh_q, fresh_d;
   logic [2:0] over_q, over_d;
   logic [2:0] seen_q, seen_d;
   logic all_fresh_q, all_fresh_d;
   logic all_over_q, all_over_d;
   logic all_read;

   always_comb
   begin
      all_read = &(seen_q | high_read);
      // a new sample starts a fresh round of high-byte reads
      seen_d = new_sample ? RSR_RST_FLAGS : (seen_q | high_read);
      // set wins over a high-byte read clear in the same cycle; a mode clear keeps only the fresh sets
      fresh_d = (fresh_q & ~high_read) | {3{new_sample}};
      over_d = (over_q & ~high_read) | ({3{new_sample}} & fresh_q);
      all_fresh_d = (all_fresh_q && !all_read) || new_sample;
      all_over_d = (all_over_q && !all_read) || (new_sample && all_fresh_q);
      if (mode_clear)
      begin
         fresh_d = {3{new_sample}};
         over_d = RSR_RST_FLAGS;
         seen_d = RSR_RST_FLAGS;
         all_fresh_d = new_sample;
         all_over_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         fresh_q <= RSR_RST_FLAGS;
         over_q <= RSR_RST_FLAGS;
         seen_q <= RSR_RST_FLAGS;
         all_fresh_q <= 1'b0;
         all_over_q <= 1'b0;
      end
      else if (clk_en)
      begin
         fresh_q <= fresh_d;
         over_q <= over_d;
         seen_q <= seen_d;
         all_fresh_q <= all_fresh_d;
         all_over_q <= all_over_d;
      end
   end

   always_comb
   begin
      status = RSR_RST_BYTE;
      status[RSR_BIT_ALL_OVERRUN] = all_over_q;
      status[RSR_BIT_Z_OVERRUN] = over_q[RSR_AXIS_Z];
      status[RSR_BIT_Y_OVERRUN] = over_q[RSR_AXIS_Y];
      status[RSR_BIT_X_OVERRUN] = over_q[RSR_AXIS_X];
      status[RSR_BIT_ALL_FRESH] = all_fresh_q;
      status[RSR_BIT_Z_FRESH] = fresh_q[RSR_AXIS_Z];
      status[RSR_BIT_Y_FRESH] = fresh_q[RSR_AXIS_Y];
      status[RSR_BIT_X_FRESH] = fresh_q[RSR_AXIS_X];
   end

endmodule

// >>> verif/rsr_readout_props.sv
// concurrent checks on the rate sample readout ports
`timescale 1ns/1ps
module rsr_readout_props
   import rsr_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // sample intake and fifo head
   input wire logic smp_valid,
   input wire logic smp_ready,
   input wire logic [7:0] fifo_status,
   input wire logic head_advance,
   // configuration
   input wire logic [1:0] fifo_mode,
   input wire logic [1:0] op_mode,
   input wire logic wrap_select,
   // register read port
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_rd_data,
   input wire logic reg_rd_valid,
   input wire logic [7:0] reg_next_addr
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   wire logic take = reg_rd && clk_en;
   wire logic buffered = fifo_mode != RSR_FIFO_MODE_DIRECT;
   wire logic pop_req = take && buffered && reg_addr == RSR_ADDR_Z_HIGH;
   // a read in the switch cycle stalls draining, so no sample can set fresh again there
   sequence go_active;
      take && op_mode == RSR_OP_ACTIVE && $past(clk_en)
         && ($past(op_mode) == RSR_OP_STANDBY || $past(op_mode) == RSR_OP_READY);
   endsequence
   a_read_answer: assert property (take |=> reg_rd_valid)
      else $error("read request got no answer");
   a_no_spurious: assert property (clk_en && !reg_rd |=> !reg_rd_valid)
      else $error("answer without a read request");
   a_wrap_target: assert property (take && reg_addr == RSR_ADDR_Z_LOW |=>
      reg_next_addr == ($past(wrap_select) ? RSR_ADDR_X_HIGH : RSR_ADDR_STATUS_ALIAS))
      else $error("wrong address after z low byte");
   a_addr_step: assert property (take && reg_addr != RSR_ADDR_Z_LOW |=>
      reg_next_addr == $past(reg_addr) + 8'h01)
      else $error("auto increment off");
   a_status_alias: assert property (take && buffered && reg_addr == 8'h00 |=>
      reg_rd_data == $past(fifo_status))
      else $error("alias does not show fifo status");
   a_pop_on_z: assert property (pop_req |=> head_advance)
      else $error("z high read did not pop");
   a_pop_cause: assert property (head_advance && $past(clk_en) |-> $past(pop_req))
      else $error("pop without z high read");
   a_all_read_clear: assert property (take && reg_addr == RSR_ADDR_X_HIGH ##1 take
      ##1 take && reg_addr == RSR_ADDR_Y_HIGH ##1 take ##1 take && reg_addr == RSR_ADDR_Z_HIGH
      ##1 take ##1 take && reg_addr == RSR_ADDR_READY_STATE |=> reg_rd_data == 8'h00)
      else $error("flags left after all high reads");
   a_fresh_summary: assert property (reg_rd_valid && $past(clk_en) &&
      $past(reg_addr) == RSR_ADDR_READY_STATE |-> reg_rd_data[3] == |reg_rd_data[2:0])
      else $error("combined fresh disagrees with axes");
   a_mode_clear: assert property (go_active ##1 take &&
      reg_addr == RSR_ADDR_READY_STATE |=> reg_rd_data == 8'h00)
      else $error("status kept over mode switch");
   c_wrap_x: cover property (take && reg_addr == RSR_ADDR_Z_LOW && wrap_select);
   c_pop: cover property (head_advance);
   c_full: cover property (clk_en && !smp_ready);
   c_intake: cover property (clk_en && smp_valid && smp_ready);
endmodule

// >>> verif/rsr_host_model.sv
// host reader that fetches register bursts from the readout block
`timescale 1ns/1ps
module rsr_host_model
   import rsr_pkg::*;
(
   // clock
   input wire logic clk,
   // read request
   output logic reg_rd,
   output logic [7:0] reg_addr,
   // read answer
   input wire logic [7:0] reg_rd_data,
   input wire logic reg_rd_valid
);
   logic [7:0] got [0:15];
   int cnt;
   initial
   begin
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      cnt = 0;
   end
   // the answer stands one cycle only
   always @(posedge clk)
   begin
      if (reg_rd_valid)
      begin
         got[cnt[3:0]] <= reg_rd_data;
         cnt <= cnt + 1;
      end
   end
   // one unbroken burst of n reads, starting at address a
   task automatic burst(input logic [7:0] a, input int n);
      int i;
      cnt = 0;
      for (i = 0; i < n; i++)
      begin
         @(posedge clk);
         reg_rd <= 1'b1;
         reg_addr <= a + i[7:0];
      end
      @(posedge clk);
      reg_rd <= 1'b0;
      // an idle address bus does not keep its last value
      reg_addr <= ~reg_addr;
      repeat (2) @(posedge clk);
   endtask
endmodule

// >>> verif/rsr_readout_tb.sv
// self-checking bench for the rate sample readout
`timescale 1ns/1ps
module rsr_readout_tb
   import rsr_pkg::*;
;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic clk_en = 1'b1;
   logic smp_valid = 1'b0;
   logic [15:0] smp_x = 16'h0000, smp_y = 16'h0000, smp_z = 16'h0000;
   logic [15:0] head_x = 16'h0000, head_y = 16'h0000, head_z = 16'h0000;
   logic [7:0] fifo_status = 8'h00;
   logic [1:0] fifo_mode = RSR_FIFO_MODE_DIRECT;
   logic [1:0] op_mode = RSR_OP_ACTIVE;
   logic wrap_select = 1'b0;
   logic reg_rd, smp_ready, head_advance, reg_rd_valid;
   logic [7:0] reg_addr, reg_rd_data, reg_next_addr;
   int error_cnt = 0;
   int checked = 0;
   int pops = 0;
   always #10 clk = ~clk;
   always @(posedge clk)
      if (head_advance)
         pops <= pops + 1;
   rsr_readout u_rsr_readout (.clk, .reset_n, .clk_en, .smp_valid, .smp_x, .smp_y, .smp_z,
      .smp_ready, .head_x, .head_y, .head_z, .fifo_status, .head_advance, .fifo_mode,
      .op_mode, .wrap_select, .reg_rd, .reg_addr, .reg_rd_data, .reg_rd_valid, .reg_next_addr);
   rsr_host_model u_rsr_host_model (.clk, .reg_rd, .reg_addr, .reg_rd_data, .reg_rd_valid);
   task automatic results();
      if (error_cnt == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // exp holds the n bytes right aligned, first byte read highest
   task automatic rd(input logic [7:0] a, input int n, input logic [63:0] exp);
      int i;
      u_rsr_host_model.burst(a, n);
      for (i = 0; i < n; i++)
         chk($sformatf("reg %h", a + i[7:0]), {8'h00, exp[8*(n-1-i)+:8]},
            {8'h00, u_rsr_host_model.got[i]});
   endtask
   task automatic push(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
      int k;
      k = 0;
      @(posedge clk);
      smp_valid <= 1'b1;
      smp_x <= x;
      smp_y <= y;
      smp_z <= z;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (smp_ready !== 1'b1 && k < 50);
      chk("sample taken", 16'h0001, {15'h0000, smp_ready});
      smp_valid <= 1'b0;
      smp_x <= ~x;
      smp_y <= ~y;
      smp_z <= ~z;
   endtask
   initial
   begin
      int m;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      rd(8'h00, 7, 64'h0);
      chk("next addr", {8'h00, RSR_ADDR_STATUS_ALIAS}, {8'h00, reg_next_addr});
      rd(8'h07, 2, 64'h0);
      chk("next addr", 16'h0009, {8'h00, reg_next_addr});
      push(16'h8123, 16'h7f45, 16'hfe67);
      repeat (4) @(posedge clk);
      rd(8'h07, 1, 64'h0f);
      rd(8'h01, 7, 64'h8123_7f45_fe67_00);
      push(16'h0102, 16'h0304, 16'h0506);
      push(16'h8a9b, 16'hacbd, 16'hcedf);
      repeat (4) @(posedge clk);
      rd(8'h01, 1, 64'h8a);
      rd(8'h07, 1, 64'hee);
      wrap_select <= 1'b1;
      rd(8'h02, 5, 64'h9b_acbd_cedf);
      chk("next addr", {8'h00, RSR_ADDR_X_HIGH}, {8'h00, reg_next_addr});
      rd(8'h07, 1, 64'h00);
      for (m = 0; m < 2; m++)
      begin
         push(16'h1111, 16'h2222, 16'h3333);
         repeat (4) @(posedge clk);
         op_mode <= (m == 0) ? RSR_OP_STANDBY : RSR_OP_READY;
         repeat (2) @(posedge clk);
         // the switch lands while the burst is already reading, so nothing drains
         fork
            rd(8'h06, 2, 64'hdf00);
            begin
               @(posedge clk);
               op_mode <= RSR_OP_ACTIVE;
            end
         join
      end
      fifo_mode <= 2'h1;
      fifo_status <= 8'ha5;
      head_x <= 16'hc001;
      head_y <= 16'h4002;
      head_z <= 16'h8003;
      pops = 0;
      rd(8'h00, 1, 64'ha5);
      rd(8'h01, 4, 64'hc001_4002);
      chk("head pops", 16'h0000, pops[15:0]);
      head_z <= 16'h7777;
      rd(8'h05, 2, 64'h8003);
      chk("head pops", 16'h0001, pops[15:0]);
      push(16'h0a0b, 16'h0c0d, 16'h0e0f);
      push(16'h1a1b, 16'h1c1d, 16'h1e1f);
      @(posedge clk);
      chk("intake ready", 16'h0000, {15'h0000, smp_ready});
      fifo_mode <= RSR_FIFO_MODE_DIRECT;
      repeat (6) @(posedge clk);
      chk("intake ready", 16'h0001, {15'h0000, smp_ready});
      rd(8'h07, 1, 64'hff);
      rd(8'h01, 7, 64'h1a1b_1c1d_1e1f_00);
      clk_en <= 1'b0;
      u_rsr_host_model.burst(8'h07, 1);
      chk("frozen answers", 16'h0000, u_rsr_host_model.cnt[15:0]);
      clk_en <= 1'b1;
      results();
   end
   // the sequence needs well under 1000 cycles
   initial
   begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      results();
   end
endmodule
bind rsr_readout rsr_readout_props u_rsr_readout_props (.clk, .reset_n, .clk_en, .smp_valid,
   .smp_ready, .fifo_status, .head_advance, .fifo_mode, .op_mode, .wrap_select, .reg_rd,
   .reg_addr, .reg_rd_data, .reg_rd_valid, .reg_next_addr);
